// ===== npiu_nested_priority_interrupt_unit.sv
// nested priority interrupt unit: arbitration, level tracking, wishbone regs
// Functional notes
// - any pending request wakes the core from wait
// - only halt-capable sources wake from halt; others stay pending
// - first service after halt exit is a halt-capable request, normal order
// - a non-capable top request is serviced right after the first one
// - concurrent mode lets only nmi preempt; nested mode lets higher levels preempt
// - fixed order rises from main through sources eight to one, nmi top
// - stack overflow from deep nesting is not detected
// - current level sits in flag bits 5 and 3, codes 10,01,00,11
// - entering a maskable routine loads the level from its vector pair
// - nmi, trap and reset preempt level 3 code
// - nmi, trap, reset have no programmable level; service sets 11
// - four 8-bit priority regs reset ff; top nibble of last reads ones
// - vector 0 pair at highest address below trap and reset, each next two bytes lower
// - a write of 10 into a pair keeps the old pair value
// - nmi priority bits are read/write but ignored by arbitration
// - raised level on a pending running vector re-enters, else unchanged
// - halt, wait, enable load 10; disable, trap load 11; return, pop restore
// - instruction level changes persist to next return or such instruction
// - vector map order and halt-exit capability per source
// - maskable service needs enable and level above the current one
// - at instruction end core stacks context then fetches the chosen vector
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
module npiu_nested_priority_interrupt_unit
	import npiu_pkg::*;
#(
	parameter logic [8:0] HALT_CAP = npiu_pkg::NPIU_HALT_CAP
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [4:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// interrupt sources, level requests from peripherals on clk_i
	input wire logic [8:0] src_req_i,
	input wire logic [8:0] src_en_i,
	// core side
	input wire logic instr_valid_i,
	input wire npiu_pkg::npiu_instr_e instr_i,
	input wire logic [7:0] instr_cc_i,
	input wire logic instr_end_i,
	input wire logic stack_done_i,
	output logic [7:0] cc_o,
	output logic branch_if_masked_o,
	output logic branch_if_unmasked_o,
	output logic take_o,
	output logic [15:0] vector_addr_o,
	output logic [3:0] vector_num_o,
	output logic wake_o,
	output logic halted_o,
	output logic waiting_o
);
	import npiu_pkg::*;

	typedef struct packed {
		logic [7:0] cc;
		logic [7:0] vp0;
		logic [7:0] vp1;
		logic [7:0] vp2;
		logic [7:0] vp3;
		logic nested;
		npiu_pwr_e pwr;
		logic halt_first;
		logic stacking;
		logic [3:0] sel_vec;
		logic [1:0] sel_lvl;
		logic trap_pend;
		logic [31:0] dat;
		logic ack;
		logic take;
		logic [15:0] vaddr;
		logic wake;
		// registered copies of the decoded status outputs
		logic masked;
		logic unmasked;
		logic halted;
		logic waiting;
	} npiu_state_s;

	npiu_state_s st, nx;

	// level code to rank: main lowest, level 3 highest
	function automatic logic [1:0] npiu_rank(input logic [1:0] code);
		unique case (code)
			NPIU_LVL0: npiu_rank = 2'h0;
			NPIU_LVL1: npiu_rank = 2'h1;
			NPIU_LVL2: npiu_rank = 2'h2;
			default: npiu_rank = 2'h3;
		endcase
	endfunction

	// merge a written pair, refusing the main-level code
	function automatic logic [7:0] npiu_wr(input logic [7:0] old_v,
			input logic [7:0] new_v);
		logic [7:0] r;
		r = old_v;
		for (int k = 0; k < 4; k++) begin
			if (new_v[2*k +: 2] != NPIU_LVL0) begin
				r[2*k +: 2] = new_v[2*k +: 2];
			end
		end
		return r;
	endfunction

	// current level pair out of a flags byte
	function automatic logic [1:0] npiu_cc_lvl(input logic [7:0] flags);
		return {flags[NPIU_CC_HI], flags[NPIU_CC_LO]};
	endfunction

	logic [55:0] vp_all;
	logic [1:0] cur_code;
	logic [1:0] cur_rank;
	logic [8:0] pend;
	logic [8:0] elig;
	logic [8:0] cand;
	logic [8:0] best_mask;
	logic [3:0] best_vec;
	logic [1:0] best_rank;
	logic any_best;
	logic [1:0] vlvl [NPIU_NUM_SRC];
	logic wb_req;

	assign vp_all = {24'h0, st.vp3, st.vp2, st.vp1, st.vp0};
	assign cur_code = npiu_cc_lvl(st.cc);
	assign cur_rank = npiu_rank(cur_code);
	// enable gating only; the source keeps its request until serviced
	assign pend = src_req_i & src_en_i;
	// ack low for a cycle after each answer keeps a held request single
	assign wb_req = cyc_i & stb_i & ~st.ack;

	// vector n's pair: vector 0 sits in the low two bits of the first priority register, vp0
	genvar g;
	generate
		for (g = 0; g < NPIU_NUM_SRC; g++) begin : g_lvl
			assign vlvl[g] = vp_all[2*g +: 2];
		end
	endgenerate

	always_comb begin
		elig = '0;
		cand = '0;
		best_rank = 2'h0;
		best_vec = 4'h0;
		any_best = 1'b0;
		best_mask = '0;
		// during halt exit only halt-capable sources compete first
		cand = (st.halt_first ? pend & HALT_CAP : pend);
		for (int i = 0; i < NPIU_NUM_SRC; i++) begin
			if (i == NPIU_V_NMI) begin
				// nmi ignores its pair and beats level 3 code
				elig[i] = cand[i];
			end else if (npiu_rank(vlvl[i]) > cur_rank) begin
				elig[i] = cand[i];
			end
		end
		// in concurrent mode only the nmi preempts a running routine
		if (!st.nested && cur_code != NPIU_LVL0) begin
			elig[8:1] = '0;
		end
		// software level first, then lowest index wins the tie
		for (int i = NPIU_NUM_SRC - 1; i >= 0; i--) begin
			if (elig[i] && (!any_best ||
					(i == NPIU_V_NMI) ||
					npiu_rank(vlvl[i]) >= best_rank)) begin
				any_best = 1'b1;
				best_vec = 4'(i);
				// the top-level source ranks above any software level
				if (i == NPIU_V_NMI) begin
					best_rank = 2'h3;
				end else begin
					best_rank = npiu_rank(vlvl[i]);
				end
			end
		end
		best_mask[best_vec] = any_best;
	end

	always_comb begin
		nx = st;
		nx.take = 1'b0;
		nx.wake = 1'b0;
		nx.ack = 1'b0;

		// wishbone: one wait state, unmapped reads zero
		if (wb_req) begin
			nx.ack = 1'b1;
			nx.dat = 32'h0;
			unique case (adr_i)
				{1'b0, NPIU_OFS_CCP}: begin
					nx.dat[7:0] = st.cc;
				end
				{1'b0, NPIU_OFS_VP0}: begin
					nx.dat[7:0] = st.vp0;
				end
				{1'b0, NPIU_OFS_VP1}: begin
					nx.dat[7:0] = st.vp1;
				end
				{1'b0, NPIU_OFS_VP2}: begin
					nx.dat[7:0] = st.vp2;
				end
				NPIU_OFS_VP3: begin
					nx.dat[7:0] = st.vp3 | NPIU_VP3_RO;
				end
				NPIU_OFS_CTRL: begin
					nx.dat[0] = st.nested;
				end
				NPIU_OFS_STAT: begin
					// the status word carries only the low six request bits
					nx.dat[12:0] = {st.sel_vec, st.pwr, pend[5:0],
						st.halt_first};
				end
				default: begin
					nx.dat = 32'h0;
				end
			endcase

			// lane 0 carries the only byte; flags are not bus writable
			if (we_i && sel_i[0]) begin
				unique case (adr_i)
					{1'b0, NPIU_OFS_VP0}: begin
						nx.vp0 = npiu_wr(st.vp0, dat_i[7:0]);
					end
					{1'b0, NPIU_OFS_VP1}: begin
						nx.vp1 = npiu_wr(st.vp1, dat_i[7:0]);
					end
					{1'b0, NPIU_OFS_VP2}: begin
						nx.vp2 = npiu_wr(st.vp2, dat_i[7:0]);
					end
					NPIU_OFS_VP3: begin
						nx.vp3 = npiu_wr(st.vp3, dat_i[7:0]) |
							NPIU_VP3_RO;
					end
					NPIU_OFS_CTRL: begin
						nx.nested = dat_i[0];
					end
					default: begin
						// unmapped and read-only words ignore writes
						nx.nested = st.nested;
					end
				endcase
			end
		end

		// dedicated instructions; changes persist to next such op or return
		if (instr_valid_i) begin
			unique case (instr_i)
				NPIU_I_RIM: begin
					{nx.cc[NPIU_CC_HI], nx.cc[NPIU_CC_LO]} = NPIU_LVL0;
				end
				NPIU_I_SIM: begin
					{nx.cc[NPIU_CC_HI], nx.cc[NPIU_CC_LO]} = NPIU_LVL3;
				end
				NPIU_I_HALT: begin
					{nx.cc[NPIU_CC_HI], nx.cc[NPIU_CC_LO]} = NPIU_LVL0;
					nx.pwr = NPIU_HALT;
				end
				NPIU_I_WFI: begin
					{nx.cc[NPIU_CC_HI], nx.cc[NPIU_CC_LO]} = NPIU_LVL0;
					nx.pwr = NPIU_WAIT;
				end
				NPIU_I_TRAP: begin
					// the level goes to 11 when the trap is entered
					nx.trap_pend = 1'b1;
				end
				NPIU_I_INSTR_RETURN_FROM_IRQ, NPIU_I_POPCC, NPIU_I_WRCC: begin
					// the core hands back the stacked flags
					nx.cc = instr_cc_i;
				end
				default: begin
					nx.cc = st.cc;
				end
			endcase
		end

		// low power exits
		unique case (st.pwr)
			NPIU_WAIT: begin
				// any enabled request ends wait, whatever its level
				if (|pend || st.trap_pend) begin
					nx.pwr = NPIU_RUN;
					nx.wake = 1'b1;
				end
			end
			NPIU_HALT: begin
				// other sources are not latched here; their requests stay pending until the core runs again
				if (|(pend & HALT_CAP)) begin
					nx.pwr = NPIU_HALT_EXIT;
					nx.wake = 1'b1;
					nx.halt_first = 1'b1;
				end
			end
			NPIU_HALT_EXIT: begin
				nx.pwr = NPIU_RUN;
			end
			NPIU_RUN: begin
				// left only by the halt and wait instructions above
				nx.wake = 1'b0;
			end
		endcase

		// service at instruction end; stack depth is not tracked
		if (st.stacking) begin
			if (stack_done_i) begin
				nx.stacking = 1'b0;
				nx.take = 1'b1;
				nx.halt_first = 1'b0;
				{nx.cc[NPIU_CC_HI], nx.cc[NPIU_CC_LO]} = st.sel_lvl;
			end
		end else if (instr_end_i && (st.pwr == NPIU_RUN)) begin
			if (st.trap_pend) begin
				// a trap issued in this same cycle is kept pending
				nx.trap_pend = instr_valid_i && (instr_i == NPIU_I_TRAP);
				nx.stacking = 1'b1;
				nx.sel_vec = 4'hf;
				nx.sel_lvl = NPIU_LVL3;
				nx.vaddr = NPIU_VA_TRAP;
			end else if (any_best) begin
				nx.stacking = 1'b1;
				nx.sel_vec = best_vec;
				// the top-level pair is ignored; it always enters at 11
				if (best_vec == 4'(NPIU_V_NMI)) begin
					nx.sel_lvl = NPIU_LVL3;
				end else begin
					nx.sel_lvl = vlvl[best_vec];
				end
				nx.vaddr = NPIU_VA_VEC0 - {11'h0, best_vec, 1'b0};
			end
		end

		// flags come back at level 3, so no maskable source is taken until enabled
		if (rst_i) begin
			nx = '0;
			nx.cc = NPIU_CC_RST;
			nx.vp0 = NPIU_VP_RST;
			nx.vp1 = NPIU_VP_RST;
			nx.vp2 = NPIU_VP_RST;
			nx.vp3 = NPIU_VP_RST;
			nx.pwr = NPIU_RUN;
			nx.vaddr = NPIU_VA_RESET;
		end

		// decoded outputs are registered so every port leaves a flop
		nx.masked = (npiu_cc_lvl(nx.cc) == NPIU_LVL3);
		nx.unmasked = ~nx.masked;
		nx.halted = (nx.pwr == NPIU_HALT);
		nx.waiting = (nx.pwr == NPIU_WAIT);
	end

	always_ff @(posedge clk_i) begin
		st <= nx;
	end

	assign dat_o = st.dat;
	assign ack_o = st.ack;
	assign cc_o = st.cc;
	assign branch_if_masked_o = st.masked;
	assign branch_if_unmasked_o = st.unmasked;
	assign take_o = st.take;
	assign vector_addr_o = st.vaddr;
	assign vector_num_o = st.sel_vec;
	assign wake_o = st.wake;
	assign halted_o = st.halted;
	assign waiting_o = st.waiting;
endmodule

// ===== npiu_pkg.sv
// package for the nested priority interrupt unit: map, encodings, fields
package npiu_pkg;
	localparam int NPIU_NUM_VEC = 14;
	localparam int NPIU_NUM_SRC = 9;
	// wishbone word offsets (byte addresses)
	localparam logic [3:0] NPIU_OFS_CCP = 4'h0;
	localparam logic [3:0] NPIU_OFS_VP0 = 4'h4;
	localparam logic [3:0] NPIU_OFS_VP1 = 4'h8;
	localparam logic [3:0] NPIU_OFS_VP2 = 4'hc;
	localparam logic [4:0] NPIU_OFS_VP3 = 5'h10;
	localparam logic [4:0] NPIU_OFS_CTRL = 5'h14;
	localparam logic [4:0] NPIU_OFS_STAT = 5'h18;
	// condition code field positions
	localparam int NPIU_CC_HI = 5;
	localparam int NPIU_CC_LO = 3;
	localparam logic [7:0] NPIU_CC_RST = 8'hea;
	localparam logic [7:0] NPIU_VP_RST = 8'hff;
	localparam logic [7:0] NPIU_VP3_RO = 8'hf0;
	// level codes {high,low}
	localparam logic [1:0] NPIU_LVL0 = 2'h2;
	localparam logic [1:0] NPIU_LVL1 = 2'h1;
	localparam logic [1:0] NPIU_LVL2 = 2'h0;
	localparam logic [1:0] NPIU_LVL3 = 2'h3;
	// vector source indices
	localparam int NPIU_V_NMI = 0;
	localparam int NPIU_V_UART = 1;
	localparam int NPIU_V_USB = 2;
	localparam int NPIU_V_PORTC = 3;
	localparam int NPIU_V_PORTA = 4;
	localparam int NPIU_V_TBU = 5;
	localparam int NPIU_V_CARD = 6;
	localparam int NPIU_V_SUSP = 7;
	// vector addresses
	localparam logic [15:0] NPIU_VA_RESET = 16'hfffe;
	localparam logic [15:0] NPIU_VA_TRAP = 16'hfffc;
	localparam logic [15:0] NPIU_VA_VEC0 = 16'hfffa;
	// halt-exit capability of each vector source, bit n for vector n
	localparam logic [8:0] NPIU_HALT_CAP = 9'h0d8;
	typedef enum logic [1:0] {
		NPIU_RUN = 2'b00,
		NPIU_WAIT = 2'b01,
		NPIU_HALT = 2'b10,
		NPIU_HALT_EXIT = 2'b11
	} npiu_pwr_e;
	typedef enum logic [3:0] {
		NPIU_I_NONE = 4'h0,
		NPIU_I_RIM = 4'h1,
		NPIU_I_SIM = 4'h2,
		NPIU_I_HALT = 4'h3,
		NPIU_I_WFI = 4'h4,
		NPIU_I_TRAP = 4'h5,
		NPIU_I_INSTR_RETURN_FROM_IRQ = 4'h6,
		NPIU_I_POPCC = 4'h7,
		NPIU_I_WRCC = 4'h8
	} npiu_instr_e;
endpackage

// ===== npiu_asserts.sv
// port checker for the nested priority interrupt unit
module npiu_asserts
	import npiu_pkg::*;
#(
	parameter logic [8:0] HALT_CAP = 9'h0d8
) (
	// clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	// sources and core
	input wire logic [8:0] src_req_i,
	input wire logic [8:0] src_en_i,
	input wire logic instr_valid_i,
	input wire npiu_pkg::npiu_instr_e instr_i,
	input wire logic stack_done_i,
	input wire logic [7:0] cc_o,
	input wire logic branch_if_masked_o,
	input wire logic branch_if_unmasked_o,
	input wire logic take_o,
	input wire logic [15:0] vector_addr_o,
	input wire logic wake_o,
	input wire logic halted_o,
	input wire logic waiting_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	wire logic [1:0] lvl = {cc_o[5], cc_o[3]};
	bus_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("bus request not answered");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	branch_flag_a: assert property (branch_if_masked_o == (lvl == NPIU_LVL3)
		&& branch_if_unmasked_o == (lvl != NPIU_LVL3))
		else $error("branch flags disagree with level");
	disable_lvl_a: assert property (instr_valid_i && instr_i == NPIU_I_SIM
		|-> ##[1:2] lvl == NPIU_LVL3) else $error("disable did not load 11");
	enable_lvl_a: assert property (instr_valid_i && instr_i inside
		{NPIU_I_RIM, NPIU_I_HALT, NPIU_I_WFI} |-> ##[1:2] lvl == NPIU_LVL0)
		else $error("enable did not load 10");
	take_stack_a: assert property ($rose(take_o) |-> $past(stack_done_i))
		else $error("vector fetch without stacking");
	nmi_level_a: assert property (take_o && vector_addr_o == NPIU_VA_VEC0
		|-> ##[0:1] lvl == NPIU_LVL3) else $error("top level entry not at 11");
	halt_hold_a: assert property (halted_o && (src_req_i & HALT_CAP) == 9'h0
		|=> !wake_o) else $error("woke from halt without capable source");
	wait_wake_a: assert property ($rose(|(src_req_i & src_en_i)) && waiting_o
		|-> ##[0:8] wake_o) else $error("no wake from wait");
	cover property (take_o && lvl == NPIU_LVL1);
	cover property (halted_o ##1 wake_o);
	cover property (waiting_o ##1 wake_o);
endmodule
bind npiu_nested_priority_interrupt_unit npiu_asserts #(.HALT_CAP(HALT_CAP))
	u_asserts (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .src_req_i, .src_en_i,
	.instr_valid_i, .instr_i, .stack_done_i, .cc_o, .branch_if_masked_o,
	.branch_if_unmasked_o, .take_o, .vector_addr_o, .wake_o, .halted_o,
	.waiting_o);

// ===== npiu_core_model.sv
// cpu core stand-in: instruction end and context stacking handshakes
module npiu_core_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// handshakes to the unit
	output logic instr_end_o,
	output logic stack_done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			cnt <= 3'h0;
		else
			cnt <= cnt + 3'h1;
	end
	// the core cannot see stacking start, so it pulses blindly; slow on purpose
	assign instr_end_o = (cnt == 3'h7);
	assign stack_done_o = (cnt == 3'h2);
endmodule

// ===== npiu_nested_priority_interrupt_unit_test.sv
// self-checking bench for the nested priority interrupt unit
module npiu_nested_priority_interrupt_unit_test;
	import npiu_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic instr_valid_i = 1'b0, ack_o, instr_end_i, stack_done_i, take_o;
	logic wake_o, halted_o, waiting_o, bm, bu;
	logic [4:0] adr_i = 5'h00;
	logic [3:0] sel_i = 4'h1, vector_num_o;
	logic [31:0] dat_i = 32'h0, dat_o;
	logic [8:0] src_req_i = 9'h000, src_en_i = 9'h1ff;
	npiu_instr_e instr_i = NPIU_I_NONE;
	logic [7:0] instr_cc_i = 8'he2, cc_o;
	logic [15:0] vector_addr_o;
	int fail_count = 0, total_checks = 0, cycles = 0;
	npiu_nested_priority_interrupt_unit DUT (.clk_i, .rst_i, .cyc_i, .stb_i,
		.we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .src_req_i, .src_en_i,
		.instr_valid_i, .instr_i, .instr_cc_i, .instr_end_i, .stack_done_i,
		.cc_o, .branch_if_masked_o(bm), .branch_if_unmasked_o(bu), .take_o,
		.vector_addr_o, .vector_num_o, .wake_o, .halted_o, .waiting_o);
	npiu_core_model core (.clk_i, .rst_i, .instr_end_o(instr_end_i),
		.stack_done_o(stack_done_i));
	initial forever #4 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			report_and_stop();
		end
	end
	function automatic logic [15:0] lvl();
		return {14'h0, cc_o[5], cc_o[3]};
	endfunction
	task automatic check(string n, logic [15:0] seen, logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wb(logic w, logic [4:0] a, logic [7:0] d, logic [7:0] e);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		if (!w)
			check("register", dat_o[15:0], {8'h0, e});
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic op(npiu_instr_e c);
		@(posedge clk_i);
		instr_valid_i <= 1'b1;
		instr_i <= c;
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask
	task automatic take(logic [15:0] va, logic [1:0] lv);
		int i;
		logic [15:0] n;
		i = 0;
		// trap reports number f; vectors step down two bytes apiece
		n = (va == NPIU_VA_TRAP) ? 16'hf : (NPIU_VA_VEC0 - va) >> 1;
		while (take_o !== 1'b1 && i < 100) begin
			@(posedge clk_i);
			i++;
		end
		check("vector", vector_addr_o, va);
		check("vector number", {12'h0, vector_num_o}, n);
		@(posedge clk_i);
		check("entry level", lvl(), {14'h0, lv});
	endtask
	task automatic wake_wait(logic e);
		int i;
		i = 0;
		while (wake_o !== 1'b1 && i < 20) begin
			@(posedge clk_i);
			i++;
		end
		check("wake", {15'h0, wake_o}, {15'h0, e});
	endtask
	task automatic regs_scn();
		wb(1'b0, 5'h00, 8'h0, NPIU_CC_RST);
		for (int i = 1; i < 5; i++) wb(1'b0, 5'(4 * i), 8'h0, NPIU_VP_RST);
		wb(1'b0, 5'h1c, 8'h0, 8'h00);
		wb(1'b1, 5'h04, 8'hcf, 8'h0);
		wb(1'b1, 5'h04, 8'h64, 8'h0);
		wb(1'b0, 5'h04, 8'h0, 8'h44);
		wb(1'b1, 5'h04, 8'hff, 8'h0);
		wb(1'b1, 5'h10, 8'h00, 8'h0);
		wb(1'b0, 5'h10, 8'h0, NPIU_VP3_RO);
	endtask
	task automatic level_scn();
		op(NPIU_I_SIM);
		check("masked", {15'h0, bm}, 16'h1);
		check("level", lvl(), 16'h3);
		op(NPIU_I_POPCC);
		check("popped level", lvl(), 16'h2);
		op(NPIU_I_SIM);
		op(NPIU_I_RIM);
		check("unmasked", {15'h0, bu}, 16'h1);
		check("level", lvl(), 16'h2);
	endtask
	task automatic arb_scn();
		src_req_i <= 9'h018;
		take(16'hfff4, 2'h3);
		src_req_i <= 9'h000;
		op(NPIU_I_INSTR_RETURN_FROM_IRQ);
		wb(1'b1, 5'h04, 8'h7f, 8'h0);
		src_req_i <= 9'h018;
		take(16'hfff2, 2'h3);
		src_req_i <= 9'h008;
		op(NPIU_I_INSTR_RETURN_FROM_IRQ);
		take(16'hfff4, 2'h1);
		src_req_i <= 9'h000;
		op(NPIU_I_INSTR_RETURN_FROM_IRQ);
	endtask
	task automatic nmi_scn();
		op(NPIU_I_SIM);
		src_req_i <= 9'h001;
		take(NPIU_VA_VEC0, 2'h3);
		src_req_i <= 9'h000;
		op(NPIU_I_INSTR_RETURN_FROM_IRQ);
		op(NPIU_I_SIM);
		op(NPIU_I_TRAP);
		take(NPIU_VA_TRAP, 2'h3);
		op(NPIU_I_INSTR_RETURN_FROM_IRQ);
	endtask
	task automatic wait_scn();
		op(NPIU_I_WFI);
		check("waiting", {15'h0, waiting_o}, 16'h1);
		src_req_i <= 9'h020;
		wake_wait(1'b1);
		take(16'hfff0, 2'h3);
		src_req_i <= 9'h000;
		op(NPIU_I_INSTR_RETURN_FROM_IRQ);
	endtask
	task automatic halt_scn();
		wb(1'b1, 5'h14, 8'h01, 8'h0);
		op(NPIU_I_HALT);
		src_req_i <= 9'h020;
		wake_wait(1'b0);
		check("halted", {15'h0, halted_o}, 16'h1);
		src_req_i <= 9'h028;
		wake_wait(1'b1);
		take(16'hfff4, 2'h1);
		take(16'hfff0, 2'h3);
		src_req_i <= 9'h000;
		op(NPIU_I_INSTR_RETURN_FROM_IRQ);
		op(NPIU_I_INSTR_RETURN_FROM_IRQ);
	endtask
	task automatic report_and_stop();
		if (fail_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		regs_scn();
		level_scn();
		arb_scn();
		nmi_scn();
		wait_scn();
		halt_scn();
		report_and_stop();
	end
endmodule
